// ---- src/host_bridge_pkg.sv ----
package host_bridge_pkg;

  // ==========================================================================
  // Widths and address decode
  localparam int HOST_ADDR_W = 18;
  localparam int DATA_W      = 16;
  localparam int TERM_ADDR_W = 16;
  localparam int SEL_HI      = 17;
  localparam int SEL_LO      = 16;
  localparam int SUB_HI      = 2;
  localparam int SUB_LO      = 1;

  localparam logic [1:0] SEL_TERM_REG   = 2'h0;
  localparam logic [1:0] SEL_SHARED_MEM = 2'h1;
  localparam logic [1:0] SEL_CONFIG     = 2'h2;
  localparam logic [1:0] SEL_STATUS     = 2'h3;
  localparam logic [1:0] SUB_CFG_REG    = 2'h0;
  localparam logic [1:0] SUB_CFG_PINS   = 2'h1;
  localparam logic [1:0] SUB_STAT_READ  = 2'h0;
  localparam logic [1:0] SUB_STAT_CLEAR = 2'h1;

  // ==========================================================================
  // Timing, reset values and codes
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACCESS_NS     = 40;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W        = 4;
  localparam int FIFO_DEPTH    = 8;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;

  localparam logic [1:0] ARB_CODE_IDLE = 2'h0;
  localparam logic [1:0] ARB_CODE_TERM = 2'h1;
  localparam logic [1:0] ARB_CODE_HOST = 2'h2;

  // ==========================================================================
  // Carriers
  localparam int TASK_W = 2;
  localparam int COND_W = 4;
  localparam int WORD_W = TASK_W + COND_W;

  typedef struct packed {
    logic flag;
    logic msg;
    logic active;
    logic ready;
  } cond_t;

  typedef struct packed {
    logic [TASK_W-1:0] task_bits;
    cond_t             cond;
  } cond_word_t;

  typedef struct packed {
    logic                   target;
    logic [TERM_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]      data;
  } wr_cmd_t;

endpackage

// ---- src/cmd_fifo.sv ----
module cmd_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             ce_in,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // Drain side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } fifo_st_t;

  fifo_st_t         r;
  fifo_st_t         n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_out  = (r.count != CW'(DEPTH));
  assign out_valid_out = (r.count != '0);
  assign out_data_out  = mem[r.rptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    n = r;
    if (push) begin
      n.wptr = (r.wptr == PW'(DEPTH - 1)) ? '0 : PW'(r.wptr + 1'b1);
    end
    if (pop) begin
      n.rptr = (r.rptr == PW'(DEPTH - 1)) ? '0 : PW'(r.rptr + 1'b1);
    end
    n.count = CW'(r.count + CW'(push) - CW'(pop));
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= n;
    end
  end

  // The array has no reset, so it maps onto plain RAM cells.
  always_ff @(posedge sys_clk_in) begin
    if (ce_in && push) begin
      mem[r.wptr] <= in_data_in;
    end
  end

endmodule // cmd_fifo

// ---- src/status_capture.sv ----
module status_capture
  import host_bridge_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rstn_in,
  input  wire logic                 ce_in,
  // Event sources
  input  wire logic                 clr_in,
  input  wire logic [TASK_W-1:0]    task_stat_in,
  input  wire host_bridge_pkg::cond_t cond_n_in,
  // Processor side
  output host_bridge_pkg::cond_word_t word_out,
  output logic                      irq_n_out
);
  import host_bridge_pkg::*;

  typedef struct packed {
    cond_word_t word;
    logic       irq_n;
  } sc_st_t;

  sc_st_t r;
  sc_st_t n;
  cond_t  seen;

  always_comb begin
    n    = r;
    seen = ~cond_n_in;
    n.word.task_bits = task_stat_in;
    // A condition arriving with the clear is kept: set wins over clear.
    n.word.cond = clr_in ? seen : (r.word.cond | seen);
    n.irq_n = ~(n.word.cond.flag | n.word.cond.msg);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r       <= '0;
      r.irq_n <= 1'b1;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign word_out  = r.word;
  assign irq_n_out = r.irq_n;

  // ==========================================================================
  // Checks
  a_irq_from_flags: assert property (@(posedge sys_clk_in) disable iff (!rstn_in || !ce_in)
    (!cond_n_in.flag || !cond_n_in.msg) |=> !irq_n_out)
    else $error("interrupt not raised on terminal event");
  a_clear_word: assert property (@(posedge sys_clk_in) disable iff (!rstn_in || !ce_in)
    (clr_in && (cond_n_in == 4'hF)) |=> (word_out.cond == 4'h0))
    else $error("held word not cleared");

endmodule // status_capture

// ---- src/host_to_terminal_bridge.sv ----
// Functional notes
// - Resynchronise host strobes; route each access.
// - Access terminal registers, shared memory, config.
// - Decode address 17:16 and 2:1 targets.
// - Status clear from strobes, GPIO, bus use.
// - Busy holds state for the access time.
// - Drive select, read/write and output enable.
// - Startup configuration read/write; output enable tied on.
// - Capture task status and four terminal conditions.
// - Terminal conditions decide interrupt arming.
// - Hold combined word; clear on clear pulse.
// - One active-low interrupt on captured flag or message conditions.
// - Arbitrate both requests; drive matching grant.
// - Transfer acknowledge after transfer completes.
// - Terminal acknowledge timed from RAM select.
// - Arbiter status output shows current task.
module host_to_terminal_bridge
  import host_bridge_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                            sys_clk_in,
  input  wire logic                            rstn_in,
  input  wire logic                            ce_in,
  // Host memory-mapped port
  input  wire logic                            io_select_low_in,
  input  wire logic                            output_enable_low_in,
  input  wire logic                            read_strobe_in,
  input  wire logic                            write_strobe_low_in,
  input  wire logic [host_bridge_pkg::HOST_ADDR_W-1:0] host_addr_in,
  input  wire logic [host_bridge_pkg::DATA_W-1:0]      host_wdata_in,
  output logic [host_bridge_pkg::DATA_W-1:0]           host_rdata_out,
  output logic                                 host_rdata_oe_out,
  output logic                                 host_io_ready_out,
  // Host GPIO lines
  input  wire logic                            host_bus_request_n_in,
  input  wire logic                            host_bus_ack_n_in,
  output logic                                 host_bus_grant_n_out,
  output logic                                 host_transfer_ack_n_out,
  output logic                                 host_interrupt_n_out,
  output host_bridge_pkg::cond_word_t          combined_condition_word_out,
  // Terminal arbitration and conditions
  input  wire logic                            terminal_bus_request_n_in,
  input  wire logic                            terminal_bus_ack_n_in,
  output logic                                 terminal_bus_grant_n_out,
  output logic                                 terminal_transfer_ack_n_out,
  input  wire logic                            shared_ram_select_n_in,
  input  wire host_bridge_pkg::cond_t          terminal_cond_n_in,
  // Terminal and shared memory bus
  input  wire logic                            bus_in_use_in,
  output logic                                 term_sel_n_out,
  output logic                                 term_rw_out,
  output logic                                 term_doe_out,
  output logic                                 term_target_out,
  output logic [host_bridge_pkg::TERM_ADDR_W-1:0]      term_addr_out,
  output logic [host_bridge_pkg::DATA_W-1:0]           term_wdata_out,
  input  wire logic [host_bridge_pkg::DATA_W-1:0]      term_rdata_in,
  // Startup configuration path
  input  wire logic [host_bridge_pkg::DATA_W-1:0]      cfg_in,
  output logic [host_bridge_pkg::DATA_W-1:0]           cfg_out,
  output logic                                 cfg_oe_out,
  // Task status
  output logic                                 busy_out,
  output logic [host_bridge_pkg::TASK_W-1:0]           ic_stat_out,
  output logic [1:0]                           arb_stat_out
);
  import host_bridge_pkg::*;

  // ==========================================================================
  // State
  typedef enum logic [1:0] {IC_IDLE, IC_PUSH, IC_READ, IC_RELEASE} ic_state_t;
  typedef enum logic [0:0] {BE_IDLE, BE_CYCLE} be_state_t;
  typedef enum logic [1:0] {ARB_IDLE, ARB_TERM, ARB_HOST} arb_state_t;

  typedef struct packed {
    logic [3:0]             sync1;
    logic [3:0]             sync2;
    ic_state_t              ic;
    be_state_t              be;
    arb_state_t             arb;
    logic [1:0]             acc_sel;
    logic [1:0]             acc_sub;
    logic [TERM_ADDR_W-1:0] acc_addr;
    logic [DATA_W-1:0]      acc_wdata;
    logic [BUSY_W-1:0]      busy_cnt;
    logic                   cur_rd;
    logic                   done;
    logic                   clr;
    logic                   rcs_prev;
    logic [DATA_W-1:0]      rdata;
    logic                   rdata_oe;
    logic                   io_ready;
    logic                   host_grant_n;
    logic                   term_grant_n;
    logic                   host_tack_n;
    logic                   term_tack_n;
    logic                   sel_n;
    logic                   rw;
    logic                   doe;
    logic                   target;
    logic [TERM_ADDR_W-1:0] taddr;
    logic [DATA_W-1:0]      twdata;
    logic [DATA_W-1:0]      cfg;
    logic                   busy;
    logic [TASK_W-1:0]      ic_stat;
    logic [1:0]             arb_stat;
  } st_t;

  st_t     r;
  st_t     n;
  wr_cmd_t push_cmd;
  wr_cmd_t pop_cmd;
  logic    fifo_in_ready;
  logic    fifo_out_valid;
  logic    fifo_pop;
  logic    sel_now;
  logic    rd_now;
  logic    wr_now;
  logic    owned;
  logic    rcs_rise;

  function automatic logic is_local(input logic [1:0] sel);
    return (sel == SEL_CONFIG) || (sel == SEL_STATUS);
  endfunction

  function automatic logic [1:0] arb_code(input arb_state_t s);
    case (s)
      ARB_TERM: return ARB_CODE_TERM;
      ARB_HOST: return ARB_CODE_HOST;
      default:  return ARB_CODE_IDLE;
    endcase
  endfunction

  // ==========================================================================
  // Write queue between the host port and the terminal bus
  assign push_cmd.target = (r.acc_sel == SEL_SHARED_MEM);
  assign push_cmd.addr   = r.acc_addr;
  assign push_cmd.data   = r.acc_wdata;
  // Writes are posted, so a burst of host writes overlaps slow bus cycles.
  assign fifo_pop = (r.be == BE_IDLE) && owned && fifo_out_valid;

  cmd_fifo #(
    .WIDTH ($bits(wr_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .ce_in         (ce_in),
    .in_data_in    (push_cmd),
    .in_valid_in   (r.ic == IC_PUSH),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (pop_cmd),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop)
  );

  // ==========================================================================
  // Status capture
  status_capture u_status_capture (
    .sys_clk_in   (sys_clk_in),
    .rstn_in      (rstn_in),
    .ce_in        (ce_in),
    .clr_in       (r.clr),
    .task_stat_in (r.ic_stat),
    .cond_n_in    (terminal_cond_n_in),
    .word_out     (combined_condition_word_out),
    .irq_n_out    (host_interrupt_n_out)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    n = r;
    // Only the second stage reads the first stage.
    n.sync1 = {~io_select_low_in, ~output_enable_low_in, read_strobe_in,
               ~write_strobe_low_in};
    n.sync2 = r.sync1;
    sel_now  = r.sync2[3];
    rd_now   = r.sync2[3] && r.sync2[2] && r.sync2[1];
    wr_now   = r.sync2[3] && r.sync2[0];
    owned    = (r.arb == ARB_HOST) && !host_bus_ack_n_in;
    rcs_rise = !r.rcs_prev && shared_ram_select_n_in;
    n.rcs_prev    = shared_ram_select_n_in;
    n.io_ready    = 1'b0;
    n.done        = 1'b0;
    n.clr         = 1'b0;
    n.host_tack_n = 1'b1;
    n.term_tack_n = 1'b1;

    case (r.ic)
      IC_IDLE: begin
        if (rd_now || wr_now) begin
          n.acc_sel   = host_addr_in[SEL_HI:SEL_LO];
          n.acc_sub   = host_addr_in[SUB_HI:SUB_LO];
          n.acc_addr  = host_addr_in[TERM_ADDR_W-1:0];
          n.acc_wdata = host_wdata_in;
          if (is_local(n.acc_sel)) begin
            n.io_ready = 1'b1;
            n.ic       = IC_RELEASE;
            n.rdata_oe = rd_now;
            if (n.acc_sel == SEL_CONFIG) begin
              if (wr_now && (n.acc_sub == SUB_CFG_REG)) begin
                n.cfg = host_wdata_in;
              end
              n.rdata = (n.acc_sub == SUB_CFG_PINS) ? cfg_in : r.cfg;
            end else begin
              n.rdata = {{(DATA_W - WORD_W){1'b0}}, combined_condition_word_out};
              n.clr = (n.acc_sub == SUB_STAT_CLEAR) && host_bus_request_n_in
                      && host_bus_ack_n_in && !bus_in_use_in;
            end
          end else begin
            n.ic = wr_now ? IC_PUSH : IC_READ;
          end
        end
      end
      IC_PUSH: begin
        if (fifo_in_ready) begin
          n.io_ready = 1'b1;
          n.ic       = IC_RELEASE;
        end
      end
      IC_READ: begin
        if (r.done && r.cur_rd) begin
          n.rdata_oe = 1'b1;
          n.io_ready = 1'b1;
          n.ic       = IC_RELEASE;
        end
      end
      IC_RELEASE: begin
        if (!sel_now) begin
          n.rdata_oe = 1'b0;
          n.ic       = IC_IDLE;
        end
      end
      default: n.ic = IC_IDLE;
    endcase

    // Bus engine: queued writes go first so a read never overtakes them.
    case (r.be)
      BE_IDLE: begin
        if (fifo_pop) begin
          n.sel_n    = 1'b0;
          n.rw       = 1'b0;
          n.doe      = 1'b1;
          n.target   = pop_cmd.target;
          n.taddr    = pop_cmd.addr;
          n.twdata   = pop_cmd.data;
          n.cur_rd   = 1'b0;
          n.busy_cnt = BUSY_W'(ACCESS_CYC - 1);
          n.be       = BE_CYCLE;
        end else if (owned && (r.ic == IC_READ) && !r.done) begin
          n.sel_n    = 1'b0;
          n.rw       = 1'b1;
          n.doe      = 1'b0;
          n.target   = (r.acc_sel == SEL_SHARED_MEM);
          n.taddr    = r.acc_addr;
          n.cur_rd   = 1'b1;
          n.busy_cnt = BUSY_W'(ACCESS_CYC - 1);
          n.be       = BE_CYCLE;
        end
      end
      BE_CYCLE: begin
        if (r.busy_cnt != '0) begin
          n.busy_cnt = r.busy_cnt - 1'b1;
        end else begin
          n.sel_n = 1'b1;
          n.rw    = 1'b1;
          n.doe   = 1'b0;
          n.done  = 1'b1;
          n.host_tack_n = (r.arb != ARB_HOST);
          if (r.cur_rd) begin
            n.rdata = term_rdata_in;
          end
          n.be = BE_IDLE;
        end
      end
      default: n.be = BE_IDLE;
    endcase

    case (r.arb)
      ARB_IDLE: begin
        if (!terminal_bus_request_n_in) begin
          n.arb          = ARB_TERM;
          n.term_grant_n = 1'b0;
        end else if (!host_bus_request_n_in) begin
          n.arb          = ARB_HOST;
          n.host_grant_n = 1'b0;
        end
      end
      ARB_TERM: begin
        n.term_tack_n = !rcs_rise;
        if (terminal_bus_request_n_in && terminal_bus_ack_n_in) begin
          n.arb          = ARB_IDLE;
          n.term_grant_n = 1'b1;
        end
      end
      ARB_HOST: begin
        if (host_bus_request_n_in && host_bus_ack_n_in && (r.be == BE_IDLE)) begin
          n.arb          = ARB_IDLE;
          n.host_grant_n = 1'b1;
        end
      end
      default: n.arb = ARB_IDLE;
    endcase

    n.busy     = (n.be == BE_CYCLE);
    n.ic_stat  = {fifo_out_valid, n.be == BE_CYCLE};
    n.arb_stat = arb_code(n.arb);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r              <= '0;
      r.rcs_prev     <= 1'b1;
      r.host_grant_n <= 1'b1;
      r.term_grant_n <= 1'b1;
      r.host_tack_n  <= 1'b1;
      r.term_tack_n  <= 1'b1;
      r.sel_n        <= 1'b1;
      r.rw           <= 1'b1;
      r.cfg          <= CFG_RESET;
    end else if (ce_in) begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs
  assign host_rdata_out              = r.rdata;
  assign host_rdata_oe_out           = r.rdata_oe;
  assign host_io_ready_out           = r.io_ready;
  assign host_bus_grant_n_out        = r.host_grant_n;
  assign host_transfer_ack_n_out     = r.host_tack_n;
  assign terminal_bus_grant_n_out    = r.term_grant_n;
  assign terminal_transfer_ack_n_out = r.term_tack_n;
  assign term_sel_n_out              = r.sel_n;
  assign term_rw_out                 = r.rw;
  assign term_doe_out                = r.doe;
  assign term_target_out             = r.target;
  assign term_addr_out               = r.taddr;
  assign term_wdata_out              = r.twdata;
  assign cfg_out                     = r.cfg;
  assign cfg_oe_out                  = 1'b1;
  assign busy_out                    = r.busy;
  assign ic_stat_out                 = r.ic_stat;
  assign arb_stat_out                = r.arb_stat;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in || !ce_in);

  a_grant_exclusive: assert property (
    !(!host_bus_grant_n_out && !terminal_bus_grant_n_out))
    else $error("both grants active");
  a_term_priority: assert property (
    (r.arb == ARB_IDLE && !terminal_bus_request_n_in && !host_bus_request_n_in)
    |=> (!terminal_bus_grant_n_out && host_bus_grant_n_out))
    else $error("terminal not served first");
  a_host_tack_done: assert property (
    (r.be == BE_CYCLE && r.busy_cnt == 0 && r.arb == ARB_HOST)
    |=> (!host_transfer_ack_n_out ##1 host_transfer_ack_n_out))
    else $error("host transfer ack missing");
  a_term_tack_rcs: assert property (
    (r.arb == ARB_TERM && $rose(shared_ram_select_n_in))
    |=> !terminal_transfer_ack_n_out)
    else $error("terminal ack not timed from ram select");
  a_busy_hold: assert property (
    $fell(term_sel_n_out) |-> (!term_sel_n_out && busy_out) [*5] ##1 term_sel_n_out)
    else $error("bus cycle length wrong");
  a_read_no_drive: assert property (
    (!term_sel_n_out && term_rw_out) |-> !term_doe_out)
    else $error("data driven during read");
  a_stat_tracks_grant: assert property (
    (arb_stat_out == ARB_CODE_HOST) == !host_bus_grant_n_out)
    else $error("arbiter status disagrees with grant");
  a_clear_gated: assert property (
    r.clr |-> $past(host_bus_request_n_in) && $past(!bus_in_use_in))
    else $error("clear issued while bus in use");
  a_reset_release: assert property (
    $rose(rstn_in) |-> (host_bus_grant_n_out && terminal_bus_grant_n_out
                        && term_sel_n_out && host_interrupt_n_out))
    else $error("outputs not idle after reset");
  a_ready_pulse: assert property (
    host_io_ready_out |=> !host_io_ready_out)
    else $error("ready longer than one cycle");

  c_term_grant: cover property (!terminal_bus_grant_n_out ##[1:20] !terminal_transfer_ack_n_out);
  c_host_write: cover property (r.ic == IC_PUSH ##[1:40] !host_transfer_ack_n_out);
  c_host_read:  cover property (r.ic == IC_READ ##[1:40] host_rdata_oe_out);
  c_clear:      cover property (r.clr);

endmodule // host_to_terminal_bridge

// ---- dv/term_model.sv ----
// ============================================================
// Terminal and shared memory model
module term_model (
  input  wire logic        sys_clk_in,
  input  wire logic        sel_n_in,
  input  wire logic        rw_in,
  input  wire logic [15:0] addr_in,
  output logic      [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] last_r = 16'h0000;
  // Released data lines toggle, so a stale word never passes for a read.
  assign rdata_out = (!sel_n_in && rw_in) ? (addr_in ^ 16'h5A5A) : ~last_r;
  always @(posedge sys_clk_in) last_r <= rdata_out;
endmodule // term_model

// ---- dv/tb_host_to_terminal_bridge.sv ----
module tb_host_to_terminal_bridge import host_bridge_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ============================================================
  // Stimulus and observed signals
  logic clk = 0, rstn = 0, ios = 1, oe = 1, rd = 0, wr = 1, hreq = 1, hack = 1;
  logic treq = 1, tack = 1, rcs = 1, biu = 0, hoe, hrdy, hg, hta, irq, tg, tta;
  logic tsel, trw, tdoe, ttgt, cfoe, busy;
  logic [17:0] addr = 0;
  logic [15:0] wd = 0, cfgi = 16'hC3C3, trd, rdv, hrd, tad, twd, cfo;
  logic [1:0] ics, arb;
  cond_t cond = 4'hF;
  cond_word_t word;
  int n_mismatch = 0, n_checks = 0, n_hta = 0, n_sel = 0;
  logic [36:0] wcap = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (rstn && !tsel && !trw) wcap <= {ics, busy, tdoe, ttgt, tad, twd};
  always @(posedge clk) if (rstn && !hta) n_hta++;
  always @(posedge clk) if (rstn && !tsel) n_sel++;
  host_to_terminal_bridge u_host_to_terminal_bridge (.sys_clk_in(clk), .rstn_in(rstn),
    .ce_in(1'b1), .io_select_low_in(ios), .output_enable_low_in(oe), .read_strobe_in(rd),
    .write_strobe_low_in(wr), .host_addr_in(addr), .host_wdata_in(wd), .host_rdata_out(hrd),
    .host_rdata_oe_out(hoe), .host_io_ready_out(hrdy), .host_bus_request_n_in(hreq),
    .host_bus_ack_n_in(hack), .host_bus_grant_n_out(hg), .host_transfer_ack_n_out(hta),
    .host_interrupt_n_out(irq), .combined_condition_word_out(word),
    .terminal_bus_request_n_in(treq), .terminal_bus_ack_n_in(tack),
    .terminal_bus_grant_n_out(tg), .terminal_transfer_ack_n_out(tta),
    .shared_ram_select_n_in(rcs), .terminal_cond_n_in(cond), .bus_in_use_in(biu),
    .term_sel_n_out(tsel), .term_rw_out(trw), .term_doe_out(tdoe), .term_target_out(ttgt),
    .term_addr_out(tad), .term_wdata_out(twd), .term_rdata_in(trd), .cfg_in(cfgi),
    .cfg_out(cfo), .cfg_oe_out(cfoe), .busy_out(busy), .ic_stat_out(ics), .arb_stat_out(arb));
  term_model u_term_model (.sys_clk_in(clk), .sel_n_in(tsel), .rw_in(trw), .addr_in(tad),
    .rdata_out(trd));
  // ============================================================
  // Shared tasks
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [15:0] g, logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Strobes stay up until ready, so the synchroniser always sees a whole access.
  task automatic acc(logic [17:0] a, logic w, logic [15:0] d);
    int k;
    addr = a; wd = d; ios = 0; wr = !w; rd = !w; oe = w;
    k = 0;
    while (hrdy !== 1'b1 && k < 200) begin
      step(1);
      k++;
    end
    chk(hrdy, 1'b1);
    chk(hoe, !w);
    rdv = hrd;
    step(1);
    ios = 1; rd = 0; oe = 1; wr = 1;
    step(4);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_cfg();
    acc({SEL_CONFIG, 13'h0, SUB_CFG_REG, 1'b0}, 1, 16'h1234);
    chk(cfo, 16'h1234);
    acc({SEL_CONFIG, 13'h0, SUB_CFG_REG, 1'b0}, 0, 0);
    chk(rdv, 16'h1234);
    acc({SEL_CONFIG, 13'h0, SUB_CFG_PINS, 1'b0}, 0, 0);
    chk(rdv, cfgi);
    chk(cfoe, 1'b1);
  endtask
  task automatic t_irq();
    cond.msg = 0; step(1); cond.msg = 1; step(1);
    chk(irq, 0);
    chk(word, 6'h04);
    acc({SEL_STATUS, 13'h0, SUB_STAT_READ, 1'b0}, 0, 0);
    chk(rdv, 16'h0004);
    biu = 1;
    acc({SEL_STATUS, 13'h0, SUB_STAT_CLEAR, 1'b0}, 1, 0);
    chk(word, 6'h04);
    biu = 0;
    acc({SEL_STATUS, 13'h0, SUB_STAT_CLEAR, 1'b0}, 1, 0);
    chk(word, 6'h00);
    chk(irq, 1);
  endtask
  task automatic t_arb();
    int k;
    treq = 0; hreq = 0; step(2);
    chk({tg, hg, arb}, {2'b01, ARB_CODE_TERM});
    tack = 0; rcs = 0; step(2); rcs = 1;
    k = 0;
    while (tta !== 1'b0 && k < 4) begin
      step(1);
      k++;
    end
    chk(tta, 0);
    treq = 1; tack = 1; step(4);
    chk({hg, arb}, {1'b0, ARB_CODE_HOST});
    hack = 0;
    n_sel = 0;
    n_hta = 0;
    acc({SEL_SHARED_MEM, 16'h0077}, 1, 16'hBEEF);
    step(2);
    chk(wcap[15:0], 16'hBEEF);
    chk(wcap[31:16], 16'h0077);
    chk(wcap[36:32], 5'h0F);
    acc({SEL_SHARED_MEM, 16'h0042}, 0, 0);
    chk(rdv, 16'h0042 ^ 16'h5A5A);
    chk(n_sel, 2 * ACCESS_CYC);
    chk(n_hta, 2);
    hreq = 1; hack = 1; step(3);
    chk({hg, arb}, {1'b1, ARB_CODE_IDLE});
  endtask
  task automatic t_rst();
    cond.flag = 0;
    treq = 0;
    step(2);
    chk({tg, irq}, 2'b00);
    cond.flag = 1;
    treq = 1;
    rstn = 0;
    step(2);
    rstn = 1;
    chk({hg, tg, hta, tta, irq, tsel, word}, 12'hFC0);
  endtask
  initial begin
    #200us;
    n_mismatch++;
    summarize();
  end
  initial begin
    step(10);
    rstn = 1;
    chk({hg, tg, hta, tta, irq, tsel, word}, 12'hFC0);
    step(1);
    t_cfg();
    t_irq();
    t_arb();
    t_rst();
    summarize();
  end
endmodule // tb_host_to_terminal_bridge
